//--- pkg/artlc_pkg.sv
// package for the adc result trim and limit check block: register map,
// field layout and reset values.
// assumes a 16-bit unsigned conversion result and a 32-bit register port.
`default_nettype none

package artlc_pkg;

  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [15:0] low_limit_addr = 16'h20a8;
  localparam logic [15:0] low_limit_hysteresis_addr = 16'h20ac;
  localparam logic [15:0] high_limit_addr = 16'h20b0;
  localparam logic [15:0] high_limit_hysteresis_addr = 16'h20b4;
  localparam logic [15:0] jump_limit_addr = 16'h20b8;
  localparam logic [15:0] check_config_addr = 16'h20c0;
  localparam logic [15:0] irq_status_addr = 16'h20c4;
  localparam logic [15:0] irq_mask_addr = 16'h20c8;
  localparam logic [15:0] temperature_gain_trim_addr = 16'h2238;

  // ------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------
  localparam int gain_width = 15;
  localparam int gain_frac_bits = 14;
  localparam int limit_width = 16;
  localparam int event_count = 3;
  // config: enable bit, then one group-b routing bit per flag
  localparam int cfg_enable_bit = 0;
  localparam int cfg_route_lsb = 1;
  localparam int cfg_width = 4;
  // status: sticky events low, live limit flag levels and the sticky jump error above them
  localparam int status_live_lsb = 4;
  // event positions, shared by status, mask and routing
  localparam int ev_low = 0;
  localparam int ev_high = 1;
  localparam int ev_jump = 2;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [14:0] gain_reset = 15'h4000;
  localparam logic [15:0] limit_reset = 16'h0000;
  localparam logic [14:0] gain_illegal = 15'h0000;
  localparam logic [3:0] cfg_reset = 4'h0;
  localparam logic [2:0] mask_reset = 3'h0;

endpackage

`default_nettype wire

//--- hw/artlc_core.sv
// adc result postprocessing: temperature gain trim, limit checks with
// hysteresis, jump check, interrupt status and mask.
// assumes the result strobe comes from logic on sys_clk and that the
// register master never issues read and write together.
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1 - temperature conversions are scaled by their own 15-bit gain trim.
// R2 - the trim has its top bit as sign and fourteen fraction bits; the code treats the top bit as an unsigned integer bit.
// R3 - the trim resets to unity gain so results pass unchanged.
// R4 - an all-zero trim forces the corrected result to zero.
// R5 - half gain, double gain and the 1.000061 step follow from code over unity.
// R6 - limit and jump checks are optional and set by five writable registers.
// R7 - a result below the low limit sets the low-limit flag.
// R8 - the low flag holds until a result exceeds low limit plus hysteresis.
// R9 - a result above the high limit sets the high-limit flag.
// R10 - the high flag holds until a result falls below high limit minus hysteresis.
// R11 - consecutive results differing by more than the jump limit set the jump flag.
// R12 - reserved bits read zero and all limits reset to zero.
module artlc_core (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic conversion_valid,
  input wire logic [15:0] conversion_result,
  input wire logic conversion_is_temp,
  output logic corrected_valid,
  output logic [15:0] corrected_result,
  output logic [2:0] irq_flag_group_a,
  output logic [2:0] irq_flag_group_b,
  output logic irq
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [14:0] temperature_gain_value;
  logic [15:0] low_limit_value;
  logic [15:0] low_release_margin;
  logic [15:0] high_limit_value;
  logic [15:0] high_release_margin;
  logic [15:0] jump_limit_value;
  logic [3:0] check_config;
  logic [2:0] irq_mask;
  logic [2:0] irq_status;
  logic low_limit_flag;
  logic high_limit_flag;
  logic jump_error_flag;
  logic [15:0] prev_result;
  logic prev_valid;

  logic wr_gain;
  logic wr_low;
  logic wr_low_hyst;
  logic wr_high;
  logic wr_high_hyst;
  logic wr_jump;
  logic wr_cfg;
  logic wr_mask;
  logic rd_status;

  // address decode
  assign wr_gain = reg_write && (reg_addr == artlc_pkg::temperature_gain_trim_addr);
  assign wr_low = reg_write && (reg_addr == artlc_pkg::low_limit_addr);
  assign wr_low_hyst = reg_write && (reg_addr == artlc_pkg::low_limit_hysteresis_addr);
  assign wr_high = reg_write && (reg_addr == artlc_pkg::high_limit_addr);
  assign wr_high_hyst = reg_write && (reg_addr == artlc_pkg::high_limit_hysteresis_addr);
  assign wr_jump = reg_write && (reg_addr == artlc_pkg::jump_limit_addr);
  assign wr_cfg = reg_write && (reg_addr == artlc_pkg::check_config_addr);
  assign wr_mask = reg_write && (reg_addr == artlc_pkg::irq_mask_addr);
  assign rd_status = reg_read && (reg_addr == artlc_pkg::irq_status_addr);

  // trim register; only the low fifteen bits are stored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      // R3 unity at reset
      temperature_gain_value <= artlc_pkg::gain_reset;
    end else if (wr_gain) begin
      // R12 upper bits dropped
      temperature_gain_value <= reg_wdata[14:0];
    end
  end

  // limit, hysteresis and jump registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      // R12 limits reset zero
      low_limit_value <= artlc_pkg::limit_reset;
      low_release_margin <= artlc_pkg::limit_reset;
      high_limit_value <= artlc_pkg::limit_reset;
      high_release_margin <= artlc_pkg::limit_reset;
      jump_limit_value <= artlc_pkg::limit_reset;
    end else begin
      // R6 five writable thresholds
      if (wr_low) begin
        low_limit_value <= reg_wdata[15:0];
      end
      if (wr_low_hyst) begin
        low_release_margin <= reg_wdata[15:0];
      end
      if (wr_high) begin
        high_limit_value <= reg_wdata[15:0];
      end
      if (wr_high_hyst) begin
        high_release_margin <= reg_wdata[15:0];
      end
      if (wr_jump) begin
        jump_limit_value <= reg_wdata[15:0];
      end
    end
  end

  // config and mask
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      check_config <= artlc_pkg::cfg_reset;
      irq_mask <= artlc_pkg::mask_reset;
    end else begin
      if (wr_cfg) begin
        check_config <= reg_wdata[3:0];
      end
      if (wr_mask) begin
        irq_mask <= reg_wdata[2:0];
      end
    end
  end

  // ------------------------------------------------------------
  // gain trim stage
  // ------------------------------------------------------------
  logic [30:0] gain_product;
  logic [16:0] gain_scaled;
  logic [15:0] next_corrected;

  // R2 code over 0x4000 is the multiplier
  assign gain_product = conversion_result * temperature_gain_value;
  // R5 drop fraction bits
  assign gain_scaled = gain_product[30:14];

  // saturate on overflow: code 0x7fff nearly doubles and can exceed 16 bits
  always_comb begin
    next_corrected = conversion_result;
    if (conversion_is_temp) begin
      // R1 temperature path only
      if (temperature_gain_value == artlc_pkg::gain_illegal) begin
        // R4 illegal code gives zero
        next_corrected = 16'h0000;
      end else if (gain_scaled[16]) begin
        next_corrected = 16'hffff;
      end else begin
        next_corrected = gain_scaled[15:0];
      end
    end
  end

  // corrected output, one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      corrected_valid <= 1'b0;
      corrected_result <= 16'h0000;
    end else begin
      corrected_valid <= conversion_valid;
      if (conversion_valid) begin
        corrected_result <= next_corrected;
      end
    end
  end

  // ------------------------------------------------------------
  // limit and jump checks
  // ------------------------------------------------------------
  logic check_on;
  logic [16:0] low_release;
  logic [16:0] high_release;
  logic [15:0] jump_size;
  logic next_low_flag;
  logic next_high_flag;
  logic next_jump;
  logic [2:0] next_flags;
  logic [2:0] next_status;

  // R6 checks optional
  assign check_on = check_config[artlc_pkg::cfg_enable_bit] && corrected_valid;
  // seventeen bits so the sum cannot wrap
  assign low_release = {1'b0, low_limit_value} + {1'b0, low_release_margin};
  // negative release point (bit 16 set) means the flag never clears
  assign high_release = {1'b0, high_limit_value} - {1'b0, high_release_margin};
  assign jump_size = (corrected_result >= prev_result) ?
    (corrected_result - prev_result) : (prev_result - corrected_result);

  always_comb begin
    next_low_flag = low_limit_flag;
    next_high_flag = high_limit_flag;
    next_jump = 1'b0;
    if (check_on) begin
      if (corrected_result < low_limit_value) begin
        // R7 below low limit
        next_low_flag = 1'b1;
      end else if ({1'b0, corrected_result} > low_release) begin
        // R8 release above margin
        next_low_flag = 1'b0;
      end
      if (corrected_result > high_limit_value) begin
        // R9 above high limit
        next_high_flag = 1'b1;
      end else if (!high_release[16] && ({1'b0, corrected_result} < high_release)) begin
        // R10 release below margin
        next_high_flag = 1'b0;
      end
      // R11 consecutive difference
      next_jump = prev_valid && (jump_size > jump_limit_value);
    end
  end

  // flag levels and last result for the jump check
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      low_limit_flag <= 1'b0;
      high_limit_flag <= 1'b0;
      prev_result <= 16'h0000;
      prev_valid <= 1'b0;
    end else begin
      low_limit_flag <= next_low_flag;
      high_limit_flag <= next_high_flag;
      if (check_on) begin
        prev_result <= corrected_result;
        prev_valid <= 1'b1;
      end else if (!check_config[artlc_pkg::cfg_enable_bit]) begin
        // restart the jump history when checks are switched off
        prev_valid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt status, mask and flag groups
  // ------------------------------------------------------------
  // events are the rising of a limit flag and each jump
  assign next_flags = {next_jump, next_high_flag, next_low_flag};

  // read clears, but an event in the same cycle wins
  always_comb begin
    next_status = rd_status ? 3'h0 : irq_status;
    next_status[artlc_pkg::ev_low] = next_status[artlc_pkg::ev_low] |
      (next_low_flag & ~low_limit_flag);
    next_status[artlc_pkg::ev_high] = next_status[artlc_pkg::ev_high] |
      (next_high_flag & ~high_limit_flag);
    next_status[artlc_pkg::ev_jump] = next_status[artlc_pkg::ev_jump] | next_jump;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_status <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= next_status;
      irq <= |(next_status & irq_mask);
    end
  end

  // each flag drives group a or group b as its routing bit says
  genvar gi;
  generate
    for (gi = 0; gi < artlc_pkg::event_count; gi++) begin : g_route
      logic flag_level;
      // jump is a latched error until status read, limits are levels
      assign flag_level = (gi == artlc_pkg::ev_jump) ?
        next_status[gi] : next_flags[gi];
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          irq_flag_group_a[gi] <= 1'b0;
          irq_flag_group_b[gi] <= 1'b0;
        end else begin
          irq_flag_group_a[gi] <= flag_level & ~check_config[artlc_pkg::cfg_route_lsb + gi];
          irq_flag_group_b[gi] <= flag_level & check_config[artlc_pkg::cfg_route_lsb + gi];
        end
      end
    end
  endgenerate

  assign jump_error_flag = irq_status[artlc_pkg::ev_jump];

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  // R12 reserved bits read zero; unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      case (reg_addr)
        artlc_pkg::temperature_gain_trim_addr: reg_rdata <= {17'h0, temperature_gain_value};
        artlc_pkg::low_limit_addr: reg_rdata <= {16'h0, low_limit_value};
        artlc_pkg::low_limit_hysteresis_addr: reg_rdata <= {16'h0, low_release_margin};
        artlc_pkg::high_limit_addr: reg_rdata <= {16'h0, high_limit_value};
        artlc_pkg::high_limit_hysteresis_addr: reg_rdata <= {16'h0, high_release_margin};
        artlc_pkg::jump_limit_addr: reg_rdata <= {16'h0, jump_limit_value};
        artlc_pkg::check_config_addr: reg_rdata <= {28'h0, check_config};
        artlc_pkg::irq_mask_addr: reg_rdata <= {29'h0, irq_mask};
        artlc_pkg::irq_status_addr: reg_rdata <= {25'h0, jump_error_flag,
          high_limit_flag, low_limit_flag, 1'b0, irq_status};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // artlc_core

`default_nettype wire

//--- dv/artlc_core_sva.sv
// checker for artlc_core: port-level timing and value properties.
// assumes it is bound to artlc_core and sees every register write.
`timescale 1ns/1ps
`default_nettype none
module artlc_core_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic conversion_valid,
  input wire logic [15:0] conversion_result,
  input wire logic conversion_is_temp,
  input wire logic corrected_valid,
  input wire logic [15:0] corrected_result,
  input wire logic [2:0] irq_flag_group_a,
  input wire logic [2:0] irq_flag_group_b,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // -----------------------------------------
  // shadow copies of trim, limits and enable
  // -----------------------------------------
  logic [14:0] gain_sh;
  logic [15:0] low_sh;
  logic [15:0] high_sh;
  logic en_sh;
  // same write timing as the block, so a write beside a result sees old values
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gain_sh <= 15'h4000;
      low_sh <= 16'h0000;
      high_sh <= 16'h0000;
      en_sh <= 1'b0;
    end else if (reg_write) begin
      if (reg_addr == artlc_pkg::temperature_gain_trim_addr) gain_sh <= reg_wdata[14:0];
      if (reg_addr == artlc_pkg::low_limit_addr) low_sh <= reg_wdata[15:0];
      if (reg_addr == artlc_pkg::high_limit_addr) high_sh <= reg_wdata[15:0];
      if (reg_addr == artlc_pkg::check_config_addr) en_sh <= reg_wdata[0];
    end
  end
  // a plain result taken while the checks are on
  sequence chk_s;
    conversion_valid && !conversion_is_temp && en_sh;
  endsequence
  valid_pulse_a:
    assert property (conversion_valid |=> corrected_valid) else $error("no corrected pulse");
  rdata_idle_a:
    assert property (!reg_read |=> reg_rdata == 32'h0) else $error("read data not idle");
  plain_pass_a:
    assert property (conversion_valid && !conversion_is_temp |=>
      corrected_result == $past(conversion_result)) else $error("plain result altered");
  unity_gain_a:
    assert property (conversion_valid && conversion_is_temp && gain_sh == 15'h4000 |=>
      corrected_result == $past(conversion_result)) else $error("unity trim altered");
  zero_gain_a:
    assert property (conversion_valid && conversion_is_temp && gain_sh == 15'h0 |=>
      corrected_result == 16'h0) else $error("zero trim not zero");
  gain_rsv_a:
    assert property (reg_read && reg_addr == artlc_pkg::temperature_gain_trim_addr |=>
      reg_rdata[31:15] == 17'h0) else $error("trim reserved bits");
  limit_rsv_a:
    assert property (reg_read && reg_addr inside {[16'h20a8:16'h20b8]} |=>
      reg_rdata[31:16] == 16'h0) else $error("limit reserved bits");
  low_set_a:
    assert property (chk_s ##0 (conversion_result < low_sh) |-> ##2
      (irq_flag_group_a[0] || irq_flag_group_b[0])) else $error("low flag missing");
  high_set_a:
    assert property (chk_s ##0 (conversion_result > high_sh) |-> ##2
      (irq_flag_group_a[1] || irq_flag_group_b[1])) else $error("high flag missing");
endmodule // artlc_core_sva

bind artlc_core artlc_core_sva i_chk (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .conversion_valid(conversion_valid), .conversion_result(conversion_result),
  .conversion_is_temp(conversion_is_temp), .corrected_valid(corrected_valid),
  .corrected_result(corrected_result), .irq_flag_group_a(irq_flag_group_a),
  .irq_flag_group_b(irq_flag_group_b), .irq(irq));
`default_nettype wire

//--- dv/artlc_core_tb_top.sv
// self-checking bench for artlc_core: registers, gain trim, limit checks.
// assumes one 200 MHz clock and the register map of artlc_pkg.
`timescale 1ns/1ps
`default_nettype none
module artlc_core_tb_top;
  logic sys_clk;
  logic rst;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [31:0] reg_rdata;
  logic conversion_valid;
  logic [15:0] conversion_result;
  logic conversion_is_temp;
  logic corrected_valid;
  logic [15:0] corrected_result;
  logic [2:0] irq_flag_group_a;
  logic [2:0] irq_flag_group_b;
  logic irq;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [15:0] lims [5] = '{16'h20a8, 16'h20ac, 16'h20b0, 16'h20b4, 16'h20b8};
  logic [14:0] gains [7] = '{15'h4000, 15'h2000, 15'h7fff, 15'h4001, 15'h0001, 15'h3fff, 15'h0};
  logic [15:0] res [7] = '{16'h0200, 16'h00ff, 16'h0110, 16'h0111, 16'h0801, 16'h07e0, 16'h07df};
  logic [2:0] flg [7] = '{3'h0, 3'h1, 3'h1, 3'h0, 3'h2, 3'h2, 3'h0};
  artlc_core i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .conversion_valid(conversion_valid), .conversion_result(conversion_result),
    .conversion_is_temp(conversion_is_temp), .corrected_valid(corrected_valid),
    .corrected_result(corrected_result), .irq_flag_group_a(irq_flag_group_a),
    .irq_flag_group_b(irq_flag_group_b), .irq(irq));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ---------------------------------
  // access tasks and expected values
  // ---------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
    check("reg_rdata", reg_rdata, exp);
  endtask
  // one result; returns once the flags of that result have landed
  task automatic conv(input logic [15:0] r, input logic t, input logic [15:0] exp);
    @(posedge sys_clk);
    conversion_valid <= 1'b1;
    conversion_result <= r;
    conversion_is_temp <= t;
    @(posedge sys_clk);
    conversion_valid <= 1'b0;
    #1;
    check("corrected_result", corrected_result, exp);
    check("corrected_valid", corrected_valid, 1'b1);
    @(posedge sys_clk);
    #1;
  endtask
  // floor of result times trim over 2^14, saturated at full scale
  function automatic logic [15:0] scale(input logic [15:0] r, input logic [14:0] g);
    logic [31:0] p;
    p = (32'(r) * 32'(g)) >> 14;
    return (p > 32'h0000ffff) ? 16'hffff : p[15:0];
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // hang guard, far above the roughly 180 cycles the run needs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      end_of_test();
    end
  end
  // ---------------------------------
  // main sequence
  // ---------------------------------
  initial begin
    rst = 1'b1;
    reg_addr = 16'h0;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    conversion_valid = 1'b0;
    conversion_result = 16'h0;
    conversion_is_temp = 1'b0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(lims[i], 32'h0);
      wr(lims[i], 32'hffffffff);
      rd(lims[i], 32'h0000ffff);
    end
    rd(artlc_pkg::temperature_gain_trim_addr, 32'h4000);
    wr(artlc_pkg::temperature_gain_trim_addr, 32'hffffffff);
    rd(artlc_pkg::temperature_gain_trim_addr, 32'h7fff);
    rd(artlc_pkg::irq_mask_addr, 32'h0);
    wr(16'h20bc, 32'hffffffff);
    rd(16'h20bc, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      wr(artlc_pkg::temperature_gain_trim_addr, {17'h0, gains[i]});
      conv(16'h1234, 1'b1, scale(16'h1234, gains[i]));
      conv(16'hffff, 1'b1, scale(16'hffff, gains[i]));
    end
    conv(16'h1234, 1'b0, 16'h1234);
    $display("test gain trim done");
    wr(artlc_pkg::low_limit_addr, 32'h0100);
    wr(artlc_pkg::low_limit_hysteresis_addr, 32'h0010);
    wr(artlc_pkg::high_limit_addr, 32'h0800);
    wr(artlc_pkg::high_limit_hysteresis_addr, 32'h0020);
    wr(artlc_pkg::jump_limit_addr, 32'hffff);
    wr(artlc_pkg::check_config_addr, 32'h1);
    for (int i = 0; i < 7; i++) begin
      conv(res[i], 1'b0, res[i]);
      check("irq_flag_group_a", irq_flag_group_a, flg[i]);
    end
    wr(artlc_pkg::jump_limit_addr, 32'h0010);
    conv(16'h07d0, 1'b0, 16'h07d0);
    check("irq_flag_group_a", irq_flag_group_a, 3'h0);
    conv(16'h07e1, 1'b0, 16'h07e1);
    check("irq_flag_group_a", irq_flag_group_a, 3'h4);
    check("irq", irq, 1'b0);
    rd(artlc_pkg::irq_status_addr, 32'h47);
    @(posedge sys_clk);
    #1;
    check("irq_flag_group_a", irq_flag_group_a, 3'h0);
    $display("test limit checks done");
    wr(artlc_pkg::jump_limit_addr, 32'hffff);
    wr(artlc_pkg::irq_mask_addr, 32'h1);
    wr(artlc_pkg::check_config_addr, 32'h3);
    conv(16'h0050, 1'b0, 16'h0050);
    check("irq_flag_group_b", irq_flag_group_b, 3'h1);
    check("irq_flag_group_a", irq_flag_group_a, 3'h0);
    check("irq", irq, 1'b1);
    rd(artlc_pkg::irq_status_addr, 32'h11);
    @(posedge sys_clk);
    #1;
    check("irq", irq, 1'b0);
    // route high and jump to group b as well; mask keeps them off irq
    wr(artlc_pkg::check_config_addr, 32'hf);
    conv(16'h0900, 1'b0, 16'h0900);
    check("irq_flag_group_b", irq_flag_group_b, 3'h2);
    wr(artlc_pkg::jump_limit_addr, 32'h0010);
    conv(16'h0950, 1'b0, 16'h0950);
    check("irq_flag_group_b", irq_flag_group_b, 3'h6);
    check("irq_flag_group_a", irq_flag_group_a, 3'h0);
    check("irq", irq, 1'b0);
    $display("test routing and interrupt done");
    end_of_test();
  end
endmodule // artlc_core_tb_top
`default_nettype wire
